// File: pkg/pcm_pkg.sv
// Constants, register layout and carrier types for the codec serial port.
// Assumes a 200 MHz system clock and a plain strobe-based register port.
//
// Functional notes
// - Active bit clock edge selectable, rising or falling.
// - Frame sync and data input may be inverted.
// - Falling mode: sync sampled on next rising edge.
// - Falling mode: input data captured on falling edge.
// - Two channels, own word size and position.
// - Coding A-law, mu-law 8 bit, linear 8..16.
// - Missing packet: repeat last sample up to 24 bits.
// - Above 24 bits repeat only the last byte.
// - Alternative: programmed fill sample, limited by size.
// - Concealment choice held per channel.
// - Overflow allowed: overwrite samples not yet sent.
// - Overflow refused: drop writes while buffer full.
// - I2S mode: full duplex, two slots per frame.
// - Slot 0 left channel, slot 1 right.
// - Slot up to 40 clocks, frame up to 80.
// - Transparent coding passes data unchanged.
// - Output tri-stated between words, forced off, after reset.
// - Input and output positions per channel, one-clock steps.
package pcm_pkg;
  localparam int NCH    = 2;
  localparam int CNT_W  = 10;
  localparam int SZ_W   = 6;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 5;
  localparam int FILL_W = 24;
  localparam int CH_W   = 1;

  localparam logic [SZ_W-1:0] LAW_SIZE     = 6'h08;
  localparam logic [SZ_W-1:0] LIN_MIN      = 6'h08;
  localparam logic [SZ_W-1:0] LIN_MAX      = 6'h10;
  localparam logic [SZ_W-1:0] TRANSP_MAX   = 6'h20;
  localparam logic [SZ_W-1:0] REPEAT_MAX   = 6'h18;
  localparam logic [SZ_W-1:0] FILL_MAX     = 6'h18;
  localparam logic [SZ_W-1:0] I2S_SLOT_MAX = 6'h28;
  localparam logic [7:0]      ALAW_XOR     = 8'h55;
  localparam logic [7:0]      ULAW_XOR     = 8'hff;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_SLOT = 8'h08;
  localparam logic [7:0] ADDR_CH0  = 8'h10;
  localparam logic [7:0] ADDR_CH1  = 8'h20;
  localparam logic [3:0] OFF_CFG   = 4'h0;
  localparam logic [3:0] OFF_POS   = 4'h4;
  localparam logic [3:0] OFF_DATA  = 4'h8;
  localparam logic [3:0] OFF_FILL  = 4'hc;

  localparam int ST_OVF  = 0;
  localparam int ST_DROP = 2;
  localparam int ST_RXRD = 4;
  localparam int ST_CONC = 6;
  localparam int ST_FULL = 8;

  typedef enum logic [1:0] {CODE_ALAW, CODE_ULAW, CODE_LINEAR, CODE_TRANSP} coding_t;

  typedef struct packed {
    logic allow_ovf;
    logic dout_off;
    logic i2s;
    logic din_inv;
    logic fs_inv;
    logic edge_fall;
    logic enable;
  } ctrl_t;
  localparam int    CTRL_W   = 7;
  localparam ctrl_t CTRL_RST = 7'h00;

  typedef struct packed {
    logic [SZ_W-1:0] out_size;
    logic [SZ_W-1:0] in_size;
    logic            conceal_fill;
    coding_t         coding;
  } chan_cfg_t;
  localparam int        CFG_W   = 15;
  localparam chan_cfg_t CFG_RST = 15'h0000;

  typedef struct packed {
    logic [CNT_W-1:0] out_pos;
    logic [CNT_W-1:0] in_pos;
  } chan_pos_t;
  localparam int        POS_W   = 20;
  localparam chan_pos_t POS_RST = 20'h00000;
endpackage

// File: design/pin_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are plain levels; only the second stage is read.
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // System clock
  input  wire logic         srst,  // Synchronous reset, active high
  input  wire logic [W-1:0] d,     // Asynchronous levels
  output logic      [W-1:0] q      // Synchronised levels
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// File: design/pcm_port.sv
// Two-channel PCM / I2S codec serial port, slave to an external bit clock.
// Assumes bit clock and frame sync arrive from the codec, far below clk.
`timescale 1ns/100ps
module pcm_port (
  input  wire logic        clk,        // 200 MHz system clock
  input  wire logic        srst,       // Synchronous reset, active high
  input  wire logic [7:0]  addr,       // Register byte address
  input  wire logic [31:0] wr_data,    // Register write data
  input  wire logic        wr_en,      // Write strobe
  input  wire logic        rd_en,      // Read strobe
  output logic      [31:0] rd_data,    // Read data, cycle after rd_en
  input  wire logic        pcm_clk_in, // Codec bit clock
  input  wire logic        fsync_in,   // Codec frame sync / word select
  input  wire logic        din,        // Serial data from codec
  output logic             dout,       // Serial data to codec
  output logic             dout_oe     // Output enable of dout
);
  localparam int N = pcm_pkg::NCH;
  localparam int D = pcm_pkg::DATA_W;
  localparam int C = pcm_pkg::CNT_W;

  pcm_pkg::ctrl_t            ctrl_reg;
  logic [pcm_pkg::SZ_W-1:0]  slot_reg;
  pcm_pkg::chan_cfg_t        cfg_reg  [N];
  pcm_pkg::chan_pos_t        pos_reg  [N];
  logic [pcm_pkg::FILL_W-1:0] fill_reg [N];
  logic [D-1:0]              buf_reg  [N];
  logic [D-1:0]              last_reg [N];
  logic [D-1:0]              word_reg [N];
  logic [D-1:0]              shin_reg [N];
  logic [D-1:0]              rx_reg   [N];
  logic [N-1:0]              full_reg;
  logic [N-1:0]              ovf_reg;
  logic [N-1:0]              drop_reg;
  logic [N-1:0]              rxrd_reg;
  logic [N-1:0]              conc_reg;
  logic [C-1:0]              cnt_reg;
  logic                      sclk_prev_reg;
  logic                      fs_prev_reg;

  function automatic logic [pcm_pkg::SZ_W-1:0] eff_size(pcm_pkg::coding_t cd,
                                                         logic [pcm_pkg::SZ_W-1:0] sz);
    logic [pcm_pkg::SZ_W-1:0] r;
    r = sz;
    unique case (cd)
      pcm_pkg::CODE_ALAW, pcm_pkg::CODE_ULAW: r = pcm_pkg::LAW_SIZE;
      pcm_pkg::CODE_LINEAR:
        if (sz < pcm_pkg::LIN_MIN) r = pcm_pkg::LIN_MIN;
        else if (sz > pcm_pkg::LIN_MAX) r = pcm_pkg::LIN_MAX;
      pcm_pkg::CODE_TRANSP:
        if (sz > pcm_pkg::TRANSP_MAX) r = pcm_pkg::TRANSP_MAX;
    endcase
    return r;
  endfunction

  function automatic logic [D-1:0] size_mask(logic [pcm_pkg::SZ_W-1:0] sz);
    logic [D-1:0] m;
    m = '1;
    if (sz < pcm_pkg::TRANSP_MAX)
      m = ~(m << sz);
    return m;
  endfunction

  // Line coding of G.711 words; linear and transparent pass unchanged
  function automatic logic [D-1:0] line_code(pcm_pkg::coding_t cd, logic [D-1:0] w);
    logic [D-1:0] r;
    r = w;
    if (cd == pcm_pkg::CODE_ALAW)
      r[7:0] = w[7:0] ^ pcm_pkg::ALAW_XOR;
    else if (cd == pcm_pkg::CODE_ULAW)
      r[7:0] = w[7:0] ^ pcm_pkg::ULAW_XOR;
    return r;
  endfunction

  // Pin synchronisation and bit clock edge detection
  logic [2:0] pin_s;
  pin_sync #(.W(3)) u_pin_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({din, fsync_in, pcm_clk_in}),
    .q    (pin_s)
  );

  logic sclk_rise;
  logic sclk_fall;
  logic cap_tick;
  logic launch_tick;
  logic fs_lvl;
  logic din_lvl;
  logic frame_start;
  logic [C-1:0] cnt_new;
  logic [pcm_pkg::SZ_W-1:0] slot_eff;

  assign sclk_rise   = pin_s[0] & ~sclk_prev_reg;
  assign sclk_fall   = ~pin_s[0] & sclk_prev_reg;
  assign cap_tick    = ctrl_reg.enable & (ctrl_reg.edge_fall ? sclk_fall : sclk_rise);
  assign launch_tick = ctrl_reg.enable & (ctrl_reg.edge_fall ? sclk_rise : sclk_fall);
  assign fs_lvl      = pin_s[1] ^ ctrl_reg.fs_inv;
  assign din_lvl     = pin_s[2] ^ ctrl_reg.din_inv;
  assign frame_start = fs_lvl & ~fs_prev_reg;
  assign cnt_new     = frame_start ? '0 : ((&cnt_reg) ? cnt_reg : cnt_reg + 1'b1);
  assign slot_eff    = (slot_reg > pcm_pkg::I2S_SLOT_MAX) ? pcm_pkg::I2S_SLOT_MAX : slot_reg;

  always_ff @(posedge clk)
  begin
    if (srst)
      sclk_prev_reg <= 1'b0;
    else
      sclk_prev_reg <= pin_s[0];
  end

  // Frame sync sampled on the launch edge, opposite the capture edge
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fs_prev_reg <= 1'b0;
      cnt_reg     <= '0;
    end
    else if (launch_tick)
    begin
      fs_prev_reg <= fs_lvl;
      cnt_reg     <= cnt_new;
    end
  end

  // Per-channel window decode
  logic [N-1:0]                  out_hit;
  logic [N-1:0]                  out_first;
  logic [N-1:0]                  out_bit;
  logic [N-1:0]                  in_hit;
  logic [N-1:0]                  in_last;
  logic [N-1:0]                  take;
  logic [D-1:0]                  load_val [N];
  logic [D-1:0]                  rx_val   [N];
  logic [pcm_pkg::SZ_W-1:0]      osz      [N];
  logic [pcm_pkg::SZ_W-1:0]      isz      [N];

  for (genvar ch = 0; ch < N; ch++)
  begin : g_ch
    logic [C-1:0] opos;
    logic [C-1:0] ipos;
    logic [C:0]   oend;
    logic [C:0]   iend;
    logic [C-1:0] oidx;
    logic [C-1:0] obit;
    logic [D-1:0] conceal;
    logic [D-1:0] cur;
    logic [pcm_pkg::SZ_W-1:0] fsz;

    // In I2S mode channel 1 sits one slot after channel 0
    assign opos = pos_reg[ch].out_pos
                + ((ctrl_reg.i2s && ch == 1) ? C'(slot_eff) : '0);
    assign ipos = pos_reg[ch].in_pos
                + ((ctrl_reg.i2s && ch == 1) ? C'(slot_eff) : '0);
    assign osz[ch] = eff_size(cfg_reg[ch].coding, cfg_reg[ch].out_size);
    assign isz[ch] = eff_size(cfg_reg[ch].coding, cfg_reg[ch].in_size);
    assign oend = {1'b0, opos} + (C+1)'(osz[ch]);
    assign iend = {1'b0, ipos} + (C+1)'(isz[ch]);

    assign out_hit[ch]   = ({1'b0, cnt_new} >= {1'b0, opos}) && ({1'b0, cnt_new} < oend);
    assign out_first[ch] = launch_tick && (cnt_new == opos);
    assign in_hit[ch]    = cap_tick && ({1'b0, cnt_reg} >= {1'b0, ipos})
                         && ({1'b0, cnt_reg} < iend);
    assign in_last[ch]   = in_hit[ch] && ({1'b0, cnt_reg} == iend - 1'b1);
    assign take[ch]      = out_first[ch] & full_reg[ch];

    // Missing sample: repeat last, or insert the programmed fill
    assign fsz = (osz[ch] > pcm_pkg::FILL_MAX) ? pcm_pkg::FILL_MAX : osz[ch];
    always_comb
    begin
      conceal = '0;
      if (cfg_reg[ch].conceal_fill)
        conceal = D'(fill_reg[ch]) & size_mask(fsz);
      else if (osz[ch] <= pcm_pkg::REPEAT_MAX)
        conceal = last_reg[ch];
      else
        conceal[7:0] = last_reg[ch][7:0];
    end

    assign load_val[ch] = full_reg[ch]
                        ? line_code(cfg_reg[ch].coding, buf_reg[ch]) & size_mask(osz[ch])
                        : conceal;
    assign cur  = out_first[ch] ? load_val[ch] : word_reg[ch];
    assign oidx = cnt_new - opos;
    assign obit = C'(osz[ch]) - 1'b1 - oidx;
    assign out_bit[ch] = cur[obit[pcm_pkg::IDX_W-1:0]];
    assign rx_val[ch] = line_code(cfg_reg[ch].coding,
                                  {shin_reg[ch][D-2:0], din_lvl}) & size_mask(isz[ch]);
  end

  // Register decode
  logic         wr_ch  [N];
  logic         rd_dat [N];
  logic [3:0]   offs;
  assign offs = addr[3:0];
  for (genvar ch = 0; ch < N; ch++)
  begin : g_dec
    logic [7:0] base;
    assign base       = (ch == 0) ? pcm_pkg::ADDR_CH0 : pcm_pkg::ADDR_CH1;
    assign wr_ch[ch]  = wr_en && (addr[7:4] == base[7:4]);
    assign rd_dat[ch] = rd_en && (addr == (base | 8'(offs & pcm_pkg::OFF_DATA)))
                        && (offs == pcm_pkg::OFF_DATA);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_reg <= pcm_pkg::CTRL_RST;
      slot_reg <= '0;
    end
    else if (wr_en && addr == pcm_pkg::ADDR_CTRL)
      ctrl_reg <= pcm_pkg::ctrl_t'(wr_data[pcm_pkg::CTRL_W-1:0]);
    else if (wr_en && addr == pcm_pkg::ADDR_SLOT)
      slot_reg <= wr_data[pcm_pkg::SZ_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    for (int ch = 0; ch < N; ch++)
    begin
      if (srst)
      begin
        cfg_reg[ch]  <= pcm_pkg::CFG_RST;
        pos_reg[ch]  <= pcm_pkg::POS_RST;
        fill_reg[ch] <= '0;
      end
      else if (wr_ch[ch] && offs == pcm_pkg::OFF_CFG)
        cfg_reg[ch] <= pcm_pkg::chan_cfg_t'(wr_data[pcm_pkg::CFG_W-1:0]);
      else if (wr_ch[ch] && offs == pcm_pkg::OFF_POS)
        pos_reg[ch] <= pcm_pkg::chan_pos_t'(wr_data[pcm_pkg::POS_W-1:0]);
      else if (wr_ch[ch] && offs == pcm_pkg::OFF_FILL)
        fill_reg[ch] <= wr_data[pcm_pkg::FILL_W-1:0];
    end
  end

  // Sample buffer toward the codec and the overflow policy
  always_ff @(posedge clk)
  begin
    for (int ch = 0; ch < N; ch++)
    begin
      if (srst)
      begin
        buf_reg[ch]  <= '0;
        full_reg[ch] <= 1'b0;
        ovf_reg[ch]  <= 1'b0;
        drop_reg[ch] <= 1'b0;
      end
      else
      begin
        if (wr_en && addr == pcm_pkg::ADDR_STAT)
        begin
          ovf_reg[ch]  <= ovf_reg[ch] & ~wr_data[pcm_pkg::ST_OVF + ch];
          drop_reg[ch] <= drop_reg[ch] & ~wr_data[pcm_pkg::ST_DROP + ch];
        end
        if (take[ch])
          full_reg[ch] <= 1'b0;
        if (wr_ch[ch] && offs == pcm_pkg::OFF_DATA)
        begin
          if (full_reg[ch] && !take[ch] && !ctrl_reg.allow_ovf)
            drop_reg[ch] <= 1'b1;
          else
          begin
            buf_reg[ch]  <= wr_data;
            full_reg[ch] <= 1'b1;
            if (full_reg[ch] && !take[ch])
              ovf_reg[ch] <= 1'b1;
          end
        end
      end
    end
  end

  // Word toward the codec and record of the last real sample
  always_ff @(posedge clk)
  begin
    for (int ch = 0; ch < N; ch++)
    begin
      if (srst)
      begin
        word_reg[ch] <= '0;
        last_reg[ch] <= '0;
        conc_reg[ch] <= 1'b0;
      end
      else
      begin
        if (wr_en && addr == pcm_pkg::ADDR_STAT)
          conc_reg[ch] <= conc_reg[ch] & ~wr_data[pcm_pkg::ST_CONC + ch];
        if (out_first[ch])
        begin
          word_reg[ch] <= load_val[ch];
          if (full_reg[ch])
            last_reg[ch] <= load_val[ch];
          else
            conc_reg[ch] <= 1'b1;
        end
      end
    end
  end

  // Serial output, released whenever no word is being sent
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end
    else if (launch_tick)
    begin
      if (out_hit[0])
        dout <= out_bit[0];
      else if (out_hit[1])
        dout <= out_bit[1];
      dout_oe <= (|out_hit) & ~ctrl_reg.dout_off;
    end
    else if (!ctrl_reg.enable || ctrl_reg.dout_off)
      dout_oe <= 1'b0;
  end

  // Serial input capture
  always_ff @(posedge clk)
  begin
    for (int ch = 0; ch < N; ch++)
    begin
      if (srst)
      begin
        shin_reg[ch] <= '0;
        rx_reg[ch]   <= '0;
        rxrd_reg[ch] <= 1'b0;
      end
      else
      begin
        if (rd_dat[ch])
          rxrd_reg[ch] <= 1'b0;
        if (in_hit[ch])
          shin_reg[ch] <= {shin_reg[ch][D-2:0], din_lvl};
        if (in_last[ch])
        begin
          rx_reg[ch]   <= rx_val[ch];
          rxrd_reg[ch] <= 1'b1;
        end
      end
    end
  end

  // Read data, valid the cycle after rd_en only
  logic [31:0] stat_word;
  always_comb
  begin
    stat_word = '0;
    stat_word[pcm_pkg::ST_OVF  +: N] = ovf_reg;
    stat_word[pcm_pkg::ST_DROP +: N] = drop_reg;
    stat_word[pcm_pkg::ST_RXRD +: N] = rxrd_reg;
    stat_word[pcm_pkg::ST_CONC +: N] = conc_reg;
    stat_word[pcm_pkg::ST_FULL +: N] = full_reg;
  end

  logic [31:0] rd_mux;
  logic        rd_ch;
  always_comb
  begin
    rd_mux = '0;
    rd_ch  = addr[4] ? 1'b0 : 1'b1;
    if (addr == pcm_pkg::ADDR_CTRL)
      rd_mux = 32'(ctrl_reg);
    else if (addr == pcm_pkg::ADDR_STAT)
      rd_mux = stat_word;
    else if (addr == pcm_pkg::ADDR_SLOT)
      rd_mux = 32'(slot_reg);
    else if (addr[7:4] == pcm_pkg::ADDR_CH0[7:4] || addr[7:4] == pcm_pkg::ADDR_CH1[7:4])
    begin
      unique case (offs)
        pcm_pkg::OFF_CFG:  rd_mux = 32'(cfg_reg[rd_ch]);
        pcm_pkg::OFF_POS:  rd_mux = 32'(pos_reg[rd_ch]);
        pcm_pkg::OFF_DATA: rd_mux = rx_reg[rd_ch];
        pcm_pkg::OFF_FILL: rd_mux = 32'(fill_reg[rd_ch]);
        default:           rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rd_data <= '0;
    else if (rd_en)
      rd_data <= rd_mux;
    else
      rd_data <= '0;
  end
endmodule

// File: test/codec_model.sv
// Behavioural codec: bit clock and frame sync master, serial data both ways.
// Assumes the bench calls frame() and sets the polarity flags between frames.
`timescale 1ns/100ps
module codec_model (
  output logic      pcm_clk, // Bit clock, still between frames
  output logic      fsync,   // Frame sync
  output logic      din,     // Serial data toward the port
  input  wire logic dout,    // Serial data from the port
  input  wire logic dout_oe  // Port output enable
);
  logic        ck_inv = 1'b0;
  logic        fs_pol = 1'b0;
  logic        d_pol  = 1'b0;
  logic        lvl    = 1'b0;
  logic [63:0] cap_d  = 64'h0;
  logic [63:0] cap_oe = 64'h0;

  assign pcm_clk = lvl ^ ck_inv;
  initial
  begin
    fsync = 1'b0;
    din   = 1'b0;
  end

  // One idle clock first, so a stale sync level never hides the frame start
  task automatic frame(input int n, input logic [63:0] tx);
    #1;
    for (int p = -1; p <= n; p++)
    begin
      #40;
      lvl = 1'b1;
      if (p > 0)
      begin
        cap_d[p-1]  = dout;
        cap_oe[p-1] = dout_oe;
      end
      fsync = (p == 0) ^ fs_pol;
      #40;
      lvl = 1'b0;
      din = (p >= 0 && p < n) ? tx[p] ^ d_pol : ~din;
    end
  endtask
endmodule

// File: test/pcm_port_assertions.sv
// Checker for the codec serial port, bound to its top module.
// Assumes the register layout and bit clock handling of the package.
`timescale 1ns/100ps
module pcm_port_assertions (
  input wire logic        clk,        // System clock
  input wire logic        srst,       // Synchronous reset
  input wire logic [7:0]  addr,       // Register address
  input wire logic [31:0] wr_data,    // Write data
  input wire logic        wr_en,      // Write strobe
  input wire logic        rd_en,      // Read strobe
  input wire logic [31:0] rd_data,    // Read data
  input wire logic        pcm_clk_in, // Bit clock
  input wire logic        dout,       // Serial out
  input wire logic        dout_oe     // Serial out enable
);
  logic       en_q;
  logic       off_q;
  logic       pc_q;
  logic [3:0] ecnt;

  // Shadow of enable and forced-off, and cycles since the bit clock moved
  always_ff @(posedge clk)
  begin
    pc_q <= pcm_clk_in;
    if (srst)
    begin
      en_q  <= 1'b0;
      off_q <= 1'b0;
      ecnt  <= 4'hf;
    end
    else
    begin
      if (wr_en && addr == pcm_pkg::ADDR_CTRL)
      begin
        en_q  <= wr_data[0];
        off_q <= wr_data[5];
      end
      if (pcm_clk_in != pc_q)
        ecnt <= 4'h0;
      else if (ecnt != 4'hf)
        ecnt <= ecnt + 4'h1;
    end
  end

  a_rd_idle_zero: assert property (@(posedge clk) disable iff (srst)
    !rd_en |=> rd_data == 32'h0) else $error("read data not zero when idle");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (srst)
    rd_en && addr == 8'h0c |=> rd_data == 32'h0) else $error("unmapped read not zero");
  a_ctrl_readback: assert property (@(posedge clk) disable iff (srst)
    (wr_en && addr == pcm_pkg::ADDR_CTRL) ##2 (rd_en && addr == pcm_pkg::ADDR_CTRL)
    |=> rd_data == ($past(wr_data, 3) & 32'h7f)) else $error("control readback wrong");
  a_pos_readback: assert property (@(posedge clk) disable iff (srst)
    (wr_en && addr == 8'h14) ##2 (rd_en && addr == 8'h14)
    |=> rd_data == ($past(wr_data, 3) & 32'hfffff)) else $error("position readback wrong");
  a_oe_after_reset: assert property (@(posedge clk) disable iff (srst)
    $past(srst) |-> !dout_oe) else $error("output enabled after reset");
  a_oe_gated_off: assert property (@(posedge clk) disable iff (srst)
    (!en_q || off_q) |=> !dout_oe) else $error("output enabled while off");
  a_dout_at_edge: assert property (@(posedge clk) disable iff (srst)
    $changed(dout) |-> ecnt < 4'h8) else $error("serial out moved off a clock edge");
  a_oe_rise_edge: assert property (@(posedge clk) disable iff (srst)
    $rose(dout_oe) |-> ecnt < 4'h8 && en_q && !off_q) else $error("output enable rose wrongly");
endmodule

bind pcm_port pcm_port_assertions u_chk (
  .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .pcm_clk_in(pcm_clk_in), .dout(dout), .dout_oe(dout_oe)
);

// File: test/pcm_port_tb.sv
// Self-checking bench for the codec serial port with a codec model.
// Assumes the port is a slave to the model's bit clock and frame sync.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h exp %h", $time, (g), (e)); end end
module pcm_port_tb;
  localparam logic [7:0] CTRL = pcm_pkg::ADDR_CTRL;
  localparam logic [7:0] STAT = pcm_pkg::ADDR_STAT;
  localparam logic [7:0] CF0  = 8'h10;
  localparam logic [7:0] PS0  = 8'h14;
  localparam logic [7:0] DT0  = 8'h18;
  localparam logic [7:0] CF1  = 8'h20;
  localparam logic [7:0] PS1  = 8'h24;
  localparam logic [7:0] DT1  = 8'h28;
  localparam logic [7:0] FL1  = 8'h2c;
  logic        clk;
  logic        srst;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        pcm_clk;
  logic        fsync;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic [63:0] tx;
  int          mismatches;
  int          checks_done;

  pcm_port u_dut (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .pcm_clk_in(pcm_clk), .fsync_in(fsync), .din(din),
    .dout(dout), .dout_oe(dout_oe));
  codec_model u_codec (.pcm_clk(pcm_clk), .fsync(fsync), .din(din), .dout(dout),
    .dout_oe(dout_oe));

  function automatic logic [31:0] cfg(input logic [1:0] c, input logic f,
                                      input logic [5:0] i, input logic [5:0] o);
    return {17'h0, o, i, f, c};
  endfunction
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m = 32'hffffffff);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    `CHK(rd_data & m, e)
    @(posedge clk);
  endtask
  task automatic place(input int pos, input int sz, input logic [31:0] w);
    for (int i = 0; i < sz; i++)
      tx[pos+i] = w[sz-1-i];
  endtask
  task automatic run(input int n);
    u_codec.frame(n, tx);
    @(posedge clk);
  endtask
  // Word on the wire, MSB first, with the output driven throughout
  task automatic see(input int pos, input int sz, input logic [31:0] w);
    for (int i = 0; i < sz; i++)
    begin
      `CHK(u_codec.cap_d[pos+i], w[sz-1-i])
      `CHK(u_codec.cap_oe[pos+i], 1'b1)
    end
  endtask
  task automatic mode(input logic v);
    #1;
    u_codec.ck_inv = v;
    u_codec.fs_pol = v;
    u_codec.d_pol  = v;
    @(posedge clk);
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    logic [31:0] x;
    srst    = 1'b1;
    addr    = 8'h00;
    wr_data = 32'h0;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    mismatches  = 0;
    checks_done = 0;
    tx = {32{2'b10}};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    `CHK(dout_oe, 1'b0)
    @(posedge clk);
    reg_rd(CTRL, 32'h0);
    reg_rd(STAT, 32'h0);
    reg_rd(CF0, 32'h0);
    reg_wr(8'h0c, 32'hffffffff);
    reg_rd(8'h0c, 32'h0);
    endt("reset");
    reg_wr(CF0, cfg(2'd2, 1'b0, 6'h10, 6'h10));
    reg_wr(PS0, 32'h803);
    reg_rd(PS0, 32'h803);
    reg_wr(CF1, cfg(2'd2, 1'b1, 6'h08, 6'h08));
    reg_wr(PS1, 32'h6016);
    reg_wr(FL1, 32'h123456);
    reg_wr(CTRL, 32'h41);
    reg_rd(CTRL, 32'h41);
    reg_wr(DT0, 32'ha5c3);
    reg_wr(DT1, 32'h3c);
    place(3, 16, 32'h9e21);
    place(22, 8, 32'hb4);
    run(34);
    see(2, 16, 32'ha5c3);
    see(24, 8, 32'h3c);
    `CHK(u_codec.cap_oe[18], 1'b0)
    reg_rd(STAT, 32'h30);
    reg_rd(DT0, 32'h9e21);
    reg_rd(DT1, 32'hb4);
    endt("two channels");
    run(34);
    see(2, 16, 32'ha5c3);
    see(24, 8, 32'h56);
    reg_rd(STAT, 32'hc0, 32'hc0);
    reg_wr(STAT, 32'hc0);
    reg_rd(STAT, 32'h0, 32'hc0);
    endt("concealment");
    for (int k = 0; k < 2; k++)
    begin
      x = {24'h0, k ? pcm_pkg::ULAW_XOR : pcm_pkg::ALAW_XOR};
      reg_wr(CF0, cfg(k[1:0], 1'b0, 6'h10, 6'h10));
      reg_wr(DT0, 32'h12);
      tx = {32{2'b10}};
      place(3, 8, 32'h47);
      run(34);
      see(2, 8, 32'h12 ^ x);
      `CHK(u_codec.cap_oe[10], 1'b0)
      reg_rd(DT0, 32'h47 ^ x);
    end
    endt("companding");
    reg_wr(CF0, cfg(2'd2, 1'b0, 6'h10, 6'h10));
    reg_wr(CTRL, 32'h01);
    reg_wr(DT0, 32'h1111);
    reg_wr(DT0, 32'h2222);
    reg_rd(STAT, 32'h104, 32'h105);
    run(34);
    see(2, 16, 32'h1111);
    reg_wr(CTRL, 32'h41);
    reg_wr(DT0, 32'h3333);
    reg_wr(DT0, 32'h4444);
    reg_rd(STAT, 32'h105, 32'h105);
    run(34);
    see(2, 16, 32'h4444);
    reg_wr(STAT, 32'hf);
    reg_rd(STAT, 32'h0, 32'hf);
    endt("overflow");
    reg_wr(CTRL, 32'h4f);
    mode(1'b1);
    reg_wr(DT0, 32'h5a5a);
    tx = {32{2'b10}};
    place(3, 16, 32'hc3e1);
    run(34);
    see(2, 16, 32'h5a5a);
    reg_rd(DT0, 32'hc3e1);
    reg_wr(CTRL, 32'h41);
    mode(1'b0);
    endt("falling edge");
    reg_wr(CF0, cfg(2'd3, 1'b0, 6'h20, 6'h20));
    reg_wr(DT0, 32'h12345678);
    place(3, 32, 32'hdeadbeef);
    run(40);
    see(2, 32, 32'h12345678);
    reg_rd(DT0, 32'hdeadbeef);
    run(40);
    see(26, 8, 32'h78);
    reg_wr(CTRL, 32'h61);
    reg_wr(DT0, 32'h1);
    run(40);
    `CHK(u_codec.cap_oe[39:0], 40'h0)
    endt("transparent");
    reg_wr(pcm_pkg::ADDR_SLOT, 32'h3f);
    reg_rd(pcm_pkg::ADDR_SLOT, 32'h3f);
    reg_wr(pcm_pkg::ADDR_SLOT, 32'h10);
    reg_wr(CTRL, 32'h51);
    reg_wr(CF0, cfg(2'd2, 1'b0, 6'h10, 6'h10));
    reg_wr(PS0, 32'h0);
    reg_wr(CF1, cfg(2'd2, 1'b0, 6'h10, 6'h10));
    reg_wr(PS1, 32'h0);
    reg_wr(DT0, 32'h0f0f);
    reg_wr(DT1, 32'hf00f);
    tx = {32{2'b10}};
    place(0, 16, 32'h9e21);
    place(16, 16, 32'h6b4d);
    run(34);
    see(0, 16, 32'h0f0f);
    see(16, 16, 32'hf00f);
    reg_rd(DT0, 32'h9e21);
    reg_rd(DT1, 32'h6b4d);
    endt("i2s");
    report_and_stop();
  end
endmodule
